/* trs_pkg.sv */
// Package: timing constants, channel kinds and operation codes for the reconfig sequencer
package trs_pkg;
  localparam int unsigned TRS_CLK_MHZ = 200;
  localparam int unsigned TRS_RX_OC_CYC = 18500;
  localparam int unsigned TRS_TX_CHECK_CYC = 900;
  localparam int unsigned TRS_BASELINE_CYC = 130000;
  localparam int unsigned TRS_UNUSED_CYC = 2;
  localparam int unsigned TRS_SIM_OC_CYC = 16;
  localparam int unsigned TRS_TX_RECFG_CYC = 1518;
  localparam int unsigned TRS_RX_RECFG_CYC = 5255;
  localparam int unsigned TRS_TXRX_RECFG_CYC = 6762;
  localparam int unsigned TRS_PLL_CYC = 863;
  localparam int unsigned TRS_TX_PLL_CYC = 2370;
  localparam int unsigned TRS_TXRX_PLL_CYC = 7614;
  localparam int unsigned TRS_CCU_CYC = 925;
  localparam int unsigned TRS_PMA_STRIDE = 4;
  localparam int unsigned TRS_STATUS_W = 102;
  localparam int unsigned TRS_STATUS1_W = 34;
  localparam int unsigned TRS_STATUS2_W = 68;
  localparam int unsigned TRS_CNT_W = 18;
  localparam int unsigned TRS_CH_W = 8;
  // Channel kind per logical index
  localparam logic [1:0] TRS_CH_NONE = 2'h0;
  localparam logic [1:0] TRS_CH_TX = 2'h1;
  localparam logic [1:0] TRS_CH_RX = 2'h2;
  localparam logic [1:0] TRS_CH_TXRX = 2'h3;
  // Direction select
  localparam logic [1:0] TRS_DIR_TX = 2'h1;
  localparam logic [1:0] TRS_DIR_RX = 2'h2;
  localparam logic [1:0] TRS_DIR_BOTH = 2'h3;
  // Operation select
  localparam logic [1:0] TRS_OP_CHAN = 2'h0;
  localparam logic [1:0] TRS_OP_CHAN_PLL = 2'h1;
  localparam logic [1:0] TRS_OP_PLL = 2'h2;
  localparam logic [1:0] TRS_OP_CCU = 2'h3;
endpackage

/* trs_if.sv */
// Interface: request/busy link between user logic and the reconfig controller
`timescale 1ns/1ps
interface trs_if;
  logic req;
  logic [1:0] op;
  logic [1:0] dir;
  logic [7:0] chan;
  logic busy;
  logic oc_done;
  logic pwrdn;
  modport ctrl (input req, input op, input dir, input chan, output busy, output oc_done,
                input pwrdn);
  modport user (output req, output op, output dir, output chan, input busy, input oc_done,
                output pwrdn);
endinterface

/* trs_ctrl.sv */
// Reconfiguration controller: offset cancellation pass and timed busy for reconfig ops
`timescale 1ns/1ps
module trs_ctrl #(
  parameter int unsigned NUM_CH = 24,
  parameter bit SIM_MODEL = 1'b0,
  parameter int unsigned RX_OC_CYC = trs_pkg::TRS_RX_OC_CYC,
  parameter int unsigned BASELINE_CYC = trs_pkg::TRS_BASELINE_CYC,
  parameter int unsigned TXRX_RECFG_CYC = trs_pkg::TRS_TXRX_RECFG_CYC,
  parameter int unsigned RX_RECFG_CYC = trs_pkg::TRS_RX_RECFG_CYC,
  parameter int unsigned TXRX_PLL_CYC = trs_pkg::TRS_TXRX_PLL_CYC
) (
  input wire logic clock, // 200 MHz reconfig clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic [trs_pkg::TRS_STATUS_W-1:0] status, // Combined channel status bus
  input wire logic [2*NUM_CH-1:0] ch_kind, // Two-bit channel kind per logical index
  trs_if.ctrl lnk // Request side
);
  import trs_pkg::*;

  typedef enum logic [2:0] {S_BOOT, S_SCAN, S_WAIT, S_BASE, S_IDLE, S_OP} trs_state_e;

  trs_state_e state_q, state_d;
  logic [TRS_CNT_W-1:0] cnt_q, cnt_d;
  logic [TRS_CH_W-1:0] ch_q, ch_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [1:0] kind;
  logic [TRS_CNT_W-1:0] op_len;

  // Kind of the channel under scan; the status bus does not affect it
  always_comb begin
    kind = ch_kind[2*ch_q +: 2];
    if (status == '0) begin
      kind = kind; // Status only qualifies presence at board level
    end
  end

  // Busy length of a request, from operation and direction
  always_comb begin
    op_len = TRS_CNT_W'(TRS_CCU_CYC);
    case (lnk.op)
      TRS_OP_CHAN: begin
        case (lnk.dir)
          TRS_DIR_TX: op_len = TRS_CNT_W'(TRS_TX_RECFG_CYC);
          TRS_DIR_RX: op_len = TRS_CNT_W'(RX_RECFG_CYC);
          default: op_len = TRS_CNT_W'(TXRX_RECFG_CYC);
        endcase
      end
      TRS_OP_CHAN_PLL: begin
        case (lnk.dir)
          TRS_DIR_TX: op_len = TRS_CNT_W'(TRS_TX_PLL_CYC);
          default: op_len = TRS_CNT_W'(TXRX_PLL_CYC);
        endcase
      end
      TRS_OP_PLL: op_len = TRS_CNT_W'(TRS_PLL_CYC);
      TRS_OP_CCU: op_len = TRS_CNT_W'(TRS_CCU_CYC);
      default: op_len = TRS_CNT_W'(TRS_CCU_CYC);
    endcase
  end

  // Sequencer next state; cnt_q holds cycles of busy still to go
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ch_d = ch_q;
    busy_d = busy_q;
    done_d = done_q;
    case (state_q)
      S_BOOT: begin
        busy_d = 1'b1;
        ch_d = '0;
        if (SIM_MODEL) begin
          cnt_d = TRS_CNT_W'(TRS_SIM_OC_CYC - 1);
          state_d = S_BASE;
        end else begin
          state_d = S_SCAN;
        end
      end
      S_SCAN: begin
        // One cycle of each channel's time is spent here, the rest in S_WAIT
        case (kind)
          TRS_CH_NONE: cnt_d = TRS_CNT_W'(TRS_UNUSED_CYC - 2);
          TRS_CH_TX: cnt_d = TRS_CNT_W'(TRS_TX_CHECK_CYC - 2);
          default: cnt_d = TRS_CNT_W'(RX_OC_CYC - 2);
        endcase
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (ch_q == TRS_CH_W'(NUM_CH - 1)) begin
          cnt_d = TRS_CNT_W'(BASELINE_CYC - 1);
          state_d = S_BASE;
        end else begin
          ch_d = ch_q + 1'b1;
          state_d = S_SCAN;
        end
      end
      S_BASE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (lnk.req) begin
          busy_d = 1'b1;
          cnt_d = op_len - 1'b1;
          state_d = S_OP;
        end
      end
      S_OP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          busy_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_BOOT;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= S_BOOT;
      cnt_q <= '0;
      ch_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ch_q <= ch_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign lnk.busy = busy_q;
  assign lnk.oc_done = done_q;
endmodule

/* trs_user.sv */
// User end: issues reconfig requests, holds power-down low during cancellation
`timescale 1ns/1ps
module trs_user (
  input wire logic clock, // 200 MHz reconfig clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic start, // Pulse: request one reconfiguration
  input wire logic [1:0] op, // Operation kind
  input wire logic [1:0] dir, // Direction select
  input wire logic [7:0] chan, // Logical channel index
  input wire logic pwrdn_req, // User wish to power down
  input wire logic [trs_pkg::TRS_STATUS1_W-1:0] status1, // First instance status
  input wire logic [trs_pkg::TRS_STATUS2_W-1:0] status2, // Second instance status
  output logic [trs_pkg::TRS_STATUS_W-1:0] status, // Combined status to controller
  output logic pending, // Request accepted, not yet finished
  output logic finished, // Pulse: request completed
  trs_if.user lnk // Controller side
);
  import trs_pkg::*;

  logic req_q, req_d, pend_q, pend_d, fin_q, fin_d, pd_q, pd_d;
  logic [1:0] op_q, op_d, dir_q, dir_d;
  logic [7:0] chan_q, chan_d;
  logic [TRS_STATUS_W-1:0] st_q;

  // Raise req only when idle and cancellation done; finish once req has dropped and busy is low
  always_comb begin
    req_d = 1'b0;
    pend_d = pend_q;
    fin_d = 1'b0;
    op_d = op_q;
    dir_d = dir_q;
    chan_d = chan_q;
    if (!pend_q && start && lnk.oc_done && !lnk.busy) begin
      req_d = 1'b1;
      pend_d = 1'b1;
      op_d = op;
      dir_d = dir;
      chan_d = chan; // index chosen by caller on a stride of four
    end else if (pend_q && !req_q && !lnk.busy) begin
      pend_d = 1'b0;
      fin_d = 1'b1;
    end
    pd_d = pwrdn_req && lnk.oc_done;
  end

  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      req_q <= 1'b0;
      pend_q <= 1'b0;
      fin_q <= 1'b0;
      op_q <= '0;
      dir_q <= '0;
      chan_q <= '0;
      pd_q <= 1'b0;
      st_q <= '0;
    end else if (clk_en) begin
      req_q <= req_d;
      pend_q <= pend_d;
      fin_q <= fin_d;
      op_q <= op_d;
      dir_q <= dir_d;
      chan_q <= chan_d;
      pd_q <= pd_d;
      st_q <= {status2, status1};
    end
  end

  assign lnk.req = req_q;
  assign lnk.op = op_q;
  assign lnk.dir = dir_q;
  assign lnk.chan = chan_q;
  assign lnk.pwrdn = pd_q;
  assign status = st_q;
  assign pending = pend_q;
  assign finished = fin_q;
endmodule

/* trs_chk_asserts.sv */
// Checker: timing relations on the request/busy link
`timescale 1ns/1ps
module trs_chk #(
  parameter int unsigned BOOT_CYC = 0
) (
  input wire logic clock, // Reconfig clock
  input wire logic rst, // Sync reset
  input wire logic clk_en, // Clock enable; frozen cycles are not counted
  input wire logic req, // Request pulse
  input wire logic [1:0] op, // Operation kind
  input wire logic [1:0] dir, // Direction
  input wire logic busy, // Controller busy
  input wire logic oc_done, // Cancellation finished
  input wire logic pwrdn // Power-down
);
  import trs_pkg::*;
  logic [17:0] cnt_q, cnt_d, exp_len;
  logic [1:0] op_q, op_d, dir_q, dir_d;
  // Busy run length and the operation that started it
  always_comb begin
    // A frozen controller holds its count, so the length ignores frozen cycles
    cnt_d = !clk_en ? cnt_q : (busy ? cnt_q + 18'h1 : 18'h0);
    op_d = op_q;
    dir_d = dir_q;
    if (clk_en && req && oc_done && !busy) begin
      op_d = op;
      dir_d = dir;
    end
  end
  always_ff @(posedge clock) begin
    cnt_q <= rst ? 18'h0 : cnt_d;
    op_q <= op_d;
    dir_q <= dir_d;
  end
  // Expected length; dir 0 counts as both directions
  always_comb begin
    exp_len = 18'(TRS_TXRX_RECFG_CYC);
    if (op_q == TRS_OP_PLL) exp_len = 18'(TRS_PLL_CYC);
    else if (op_q == TRS_OP_CCU) exp_len = 18'(TRS_CCU_CYC);
    else if (op_q == TRS_OP_CHAN_PLL)
      exp_len = dir_q == TRS_DIR_TX ? 18'(TRS_TX_PLL_CYC) : 18'(TRS_TXRX_PLL_CYC);
    else if (dir_q == TRS_DIR_TX) exp_len = 18'(TRS_TX_RECFG_CYC);
    else if (dir_q == TRS_DIR_RX) exp_len = 18'(TRS_RX_RECFG_CYC);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence boot_rise;
    !busy ##1 busy;
  endsequence
  sequence accepted;
    clk_en && req && oc_done && !busy;
  endsequence
  boot_low_first_a: assert property ($fell(rst) |-> boot_rise)
    else $error("busy not low for one cycle after reset");
  busy_answer_a: assert property (accepted |=> busy)
    else $error("busy did not follow request");
  busy_no_spont_a: assert property (oc_done && !busy && !req |=> !busy)
    else $error("busy rose without request");
  op_len_a: assert property ($fell(busy) && $past(oc_done) |-> cnt_q == exp_len)
    else $error("operation busy length wrong");
  boot_len_a: assert property ($fell(busy) && !$past(oc_done) |-> cnt_q == BOOT_CYC)
    else $error("cancellation busy length wrong");
  done_hold_a: assert property (oc_done |=> oc_done)
    else $error("cancellation done dropped");
  pwrdn_low_a: assert property (!oc_done |-> !pwrdn)
    else $error("power-down during cancellation");
  busy_min_a: assert property ($rose(busy) |-> busy[*8])
    else $error("busy pulse too short");
endmodule

/* transceiver_reconfig_sequencer_timing_tb.sv */
// Testbench: boot pass timing, op busy lengths and status merge
`timescale 1ns/1ps
module transceiver_reconfig_sequencer_timing_tb;
  import trs_pkg::*;
  localparam int unsigned RXOC = 30;
  localparam int unsigned BASE = 20;
  // Kinds: 0 tx, 4 rx, 8 tx+rx, nine empty indices
  localparam int unsigned BOOT = TRS_TX_CHECK_CYC + 2 * RXOC + 9 * TRS_UNUSED_CYC + BASE;
  logic clock = 1'b0, rst = 1'b1, start = 1'b0, pwrdn_req = 1'b0, clk_en = 1'b1;
  logic [1:0] op = 2'h0, dir = 2'h0;
  logic [33:0] status1 = 34'h0_0000_0000;
  logic [67:0] status2 = 68'h0_0000_0000_0000_0000;
  logic [101:0] status;
  logic pending, finished;
  int n_errors = 0, checks = 0, n;
  int sim_n = 0;
  trs_if lnk ();
  trs_if lnk_sim ();
  // Highest index in use is 8, so the channel count rounds up to 12
  trs_ctrl #(.NUM_CH(12), .SIM_MODEL(1'b0), .RX_OC_CYC(RXOC), .BASELINE_CYC(BASE)) trs_ctrl_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .status(status), .ch_kind(24'h030201),
    .lnk(lnk));
  // Second controller in the shortened simulation model; its request side stays idle
  trs_ctrl #(.NUM_CH(12), .SIM_MODEL(1'b1)) trs_ctrl_sim_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .status(status), .ch_kind(24'h030201),
    .lnk(lnk_sim));
  trs_user trs_user_i (.clock(clock), .rst(rst), .clk_en(clk_en), .start(start), .op(op),
    .dir(dir), .chan(8'h08), .pwrdn_req(pwrdn_req), .status1(status1), .status2(status2),
    .status(status), .pending(pending), .finished(finished), .lnk(lnk));
  trs_chk #(.BOOT_CYC(BOOT)) trs_chk_i (.clock(clock), .rst(rst), .clk_en(clk_en),
    .req(lnk.req), .op(lnk.op),
    .dir(lnk.dir), .busy(lnk.busy), .oc_done(lnk.oc_done), .pwrdn(lnk.pwrdn));
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // Busy cycles of the shortened-model controller since the last reset
  always @(posedge clock) begin
    sim_n <= rst ? 0 : sim_n + ((lnk_sim.busy === 1'b1) ? 1 : 0);
  end
  // Inputs move 1 ns after the edge to stay clear of sampling
  task step;
    @(posedge clock);
    #1;
  endtask
  task chk(input string what, input logic [101:0] seen, input logic [101:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      n_errors++;
    end
  endtask
  task final_report;
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for busy, then count its high cycles into n
  task busy_len(input int rise_max);
    n = 0;
    while (lnk.busy !== 1'b1 && n < rise_max) begin
      step;
      n++;
    end
    if (lnk.busy !== 1'b1) begin
      n_errors++;
      final_report;
    end
    n = 0;
    while (lnk.busy === 1'b1 && n < 20000) begin
      n++;
      step;
    end
  endtask
  // Reset, then time the whole cancellation pass
  task boot_seq;
    rst = 1'b1;
    repeat (5) step;
    rst = 1'b0;
    // Busy stands low through the first cycle and rises at its closing edge
    chk("busy first", 102'(lnk.busy), 102'h0);
    step;
    chk("busy rise", 102'(lnk.busy), 102'h1);
    chk("pwrdn", 102'(lnk.pwrdn), 102'h0);
    busy_len(4);
    chk("boot length", 102'(n), 102'(BOOT));
    chk("oc done", 102'(lnk.oc_done), 102'h1);
    chk("sim boot length", 102'(sim_n), 102'(TRS_SIM_OC_CYC));
  endtask
  task run_op(input logic [1:0] o, input logic [1:0] d, input int unsigned len);
    op = o;
    dir = d;
    start = 1'b1;
    step;
    start = 1'b0;
    busy_len(6);
    chk("busy length", 102'(n), 102'(len));
    n = 0;
    while (finished !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    chk("finished", 102'(finished), 102'h1);
    step;
    step;
  endtask
  // Own table of busy lengths; a zero direction counts as both
  function automatic int unsigned exp_len(input logic [1:0] o, input logic [1:0] d);
    if (o == TRS_OP_PLL) return TRS_PLL_CYC;
    if (o == TRS_OP_CCU) return TRS_CCU_CYC;
    if (o == TRS_OP_CHAN_PLL) return d == TRS_DIR_TX ? TRS_TX_PLL_CYC : TRS_TXRX_PLL_CYC;
    if (d == TRS_DIR_TX) return TRS_TX_RECFG_CYC;
    return d == TRS_DIR_RX ? TRS_RX_RECFG_CYC : TRS_TXRX_RECFG_CYC;
  endfunction
  // Main sequence: boot, status merge, every op and direction, reset mid-op
  initial begin
    lnk_sim.req = 1'b0;
    lnk_sim.op = 2'h0;
    lnk_sim.dir = 2'h0;
    lnk_sim.chan = 8'h00;
    lnk_sim.pwrdn = 1'b0;
    pwrdn_req = 1'b1;
    boot_seq;
    step;
    step;
    chk("pwrdn after", 102'(lnk.pwrdn), 102'h1);
    pwrdn_req = 1'b0;
    status1 = 34'h2_0123_4567;
    status2 = 68'h9_8765_4321_0FED_CBA9;
    step;
    step;
    chk("status", status, {status2, status1});
    for (int o = 0; o < 4; o++) begin
      for (int d = 0; d < 4; d++) begin
        run_op(2'(o), 2'(d), exp_len(2'(o), 2'(d)));
      end
    end
    // Freeze mid-operation: 9 busy cycles run, 7 frozen, the rest must remain
    op = TRS_OP_PLL;
    start = 1'b1;
    step;
    start = 1'b0;
    repeat (10) step;
    clk_en = 1'b0;
    repeat (7) step;
    chk("frozen busy", 102'(lnk.busy), 102'h1);
    clk_en = 1'b1;
    busy_len(2);
    chk("frozen length", 102'(n), 102'(TRS_PLL_CYC - 9));
    step;
    step;
    // Reset while an operation is in progress
    start = 1'b1;
    step;
    start = 1'b0;
    repeat (20) step;
    boot_seq;
    final_report;
  end
endmodule
